// ---- rtl/qv_decoupling_pkg.sv ----
package qv_decoupling_pkg;
  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int          CLK_PERIOD_NS    = 10;       // hclk period in ns
  localparam int          TICK_PERIOD_US   = 1000;     // Timer resolution in us
  localparam int          TICK_CYCLES      = TICK_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam logic [15:0] TRIP_DELAY_MS    = 16'h01f4; // 500 ms default delay

  // ==========================================================================
  // Undervoltage ratio 0.85 = 17 / 20
  // ==========================================================================
  localparam logic [4:0]  UV_RATIO_NUM     = 5'h11;    // 17
  localparam logic [4:0]  UV_RATIO_DEN     = 5'h14;    // 20

  // ==========================================================================
  // Register byte offsets
  // ==========================================================================
  localparam logic [7:0]  OFS_CONTROL      = 8'h00;
  localparam logic [7:0]  OFS_NOMINAL      = 8'h04;
  localparam logic [7:0]  OFS_MIN_CURRENT  = 8'h08;
  localparam logic [7:0]  OFS_Q_THRESHOLD  = 8'h0c;
  localparam logic [7:0]  OFS_ANGLE_LIMIT  = 8'h10;
  localparam logic [7:0]  OFS_GEN_DELAY    = 8'h14;
  localparam logic [7:0]  OFS_PCC_DELAY    = 8'h18;
  localparam logic [7:0]  OFS_STATE        = 8'h1c;
  localparam logic [7:0]  OFS_IRQ_STATUS   = 8'h20;
  localparam logic [7:0]  OFS_IRQ_CLEAR    = 8'h24;
  localparam logic [7:0]  OFS_IRQ_ENABLE   = 8'h28;

  // ==========================================================================
  // Control field positions
  // ==========================================================================
  localparam int          CTL_ACTIVE_LSB   = 0;        // [3:0] activation per set
  localparam int          CTL_SET_LSB      = 4;        // [5:4] selected set
  localparam int          CTL_METHOD       = 6;        // 0 angle, 1 pure reactive
  localparam int          CTL_DIR_NEG      = 7;        // 1 negative direction
  localparam int          CTL_MIN_I_EN     = 8;        // Current gate, method 2
  localparam int          CTL_VT_SUP_EN    = 9;        // VT supervision enable
  localparam int          CTL_WIDTH        = 10;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [9:0]  CONTROL_RESET    = 10'h000;
  localparam logic [15:0] NOMINAL_RESET    = 16'h0000;
  localparam logic [15:0] MIN_I_RESET      = 16'h0000;
  localparam logic [31:0] Q_THR_RESET      = 32'h0000_0000;
  localparam logic [15:0] ANGLE_RESET      = 16'h0000;

  // Event bits: pickup, generator trip, coupling point trip
  localparam int          EV_WIDTH         = 3;

  // Detection method
  typedef enum logic [1:0] {
    METHOD_ANGLE    = 2'b01,
    METHOD_REACTIVE = 2'b10
  } method_t;
endpackage

// ---- rtl/reactive_undervoltage_decoupling.sv ----
// How it works
// - Trip after pickup persists for the set delay, half second at reset
// - All three line voltages below 0.85 nominal
// - Use positive sequence reactive power only
// - Compare phase-to-phase voltages only
// - Direction setting may invert reactive sign
// - Positive counts consumed, negative counts produced
// - Inversion stays inside this function
// - Method select: angle or pure reactive
// - Angle method always gates on current
// - Reactive method gates current when enabled
// - Method 1 compares power angle limit
// - Method 2 compares reactive power threshold
// - Both timers start at pickup
// - Per-set activation enables whole function
// - Enabled VT fault blocks the function
module reactive_undervoltage_decoupling
  import qv_decoupling_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES    // Cycles per timer tick
) (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // AHB-Lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  // Measurements, same clock domain
  input  wire logic [15:0]        voltage_l1_l2,
  input  wire logic [15:0]        voltage_l2_l3,
  input  wire logic [15:0]        voltage_l3_l1,
  input  wire logic signed [31:0] positive_seq_reactive_power,
  input  wire logic [15:0]        positive_seq_current,
  input  wire logic signed [15:0] power_angle,
  // Voltage transformer fault pin, asynchronous
  input  wire logic               vt_fault,
  // Outputs
  output logic                    generator_trip,
  output logic                    coupling_point_trip,
  output logic                    pickup,
  output logic                    irq
);

  // ==========================================================================
  // Register storage
  // ==========================================================================
  logic [CTL_WIDTH-1:0]  control;                   // Control bits
  logic [15:0]           nominal_voltage;           // Nominal line voltage
  logic [15:0]           min_positive_seq_current;  // Current gate level
  logic signed [31:0]    reactive_power_threshold;  // Method 2 threshold
  logic signed [15:0]    angle_limit;               // Method 1 angle limit
  logic [15:0]           generator_stage_delay;     // Generator timer delay, ms
  logic [15:0]           coupling_point_delay;      // Coupling timer delay, ms
  logic [EV_WIDTH-1:0]   irq_status;                // Sticky events
  logic [EV_WIDTH-1:0]   irq_enable;                // Event mask

  // Bus data phase state
  logic                  wr_pending;                // Write data phase
  logic [7:0]            wr_addr;                   // Write byte offset

  // Detection state
  logic                  vt_meta;                   // Synchroniser stage 1
  logic                  vt_sync;                   // Synchroniser stage 2
  logic [31:0]           tick_div;                  // Tick divider
  logic                  tick;                      // One-cycle tick enable
  logic [15:0]           generator_stage_timer;     // Generator timer, ms
  logic [15:0]           coupling_point_timer;      // Coupling timer, ms

  // Decision terms, combinational except the registered pickup_q
  method_t               decoupling_method_select;
  logic                  direction_negative;
  logic                  function_active;
  logic                  blocked;
  logic                  uv_all;
  logic signed [32:0]    q_dir;
  logic                  current_ok;
  logic                  reactive_demand;
  logic                  next_pickup;
  logic [EV_WIDTH-1:0]   events;
  logic                  pickup_q;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Below 0.85 of nominal: v * 20 < nominal * 17
  function automatic logic below_ratio(input logic [15:0] v, input logic [15:0] nominal);
    logic [20:0] lhs;
    logic [20:0] rhs;
    lhs = 21'(v) * 21'(UV_RATIO_DEN);
    rhs = 21'(nominal) * 21'(UV_RATIO_NUM);
    return lhs < rhs;
  endfunction

  // Exact byte offset match for a register offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // ==========================================================================
  // AHB-Lite slave, zero wait states
  // ==========================================================================
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  logic addr_phase;
  assign addr_phase = hsel && htrans[1] && hready;

  // Capture write address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pending <= 1'b0;
      wr_addr    <= 8'h00;
    end else begin
      wr_pending <= addr_phase && hwrite;
      wr_addr    <= haddr[7:0];
    end
  end

  // Register writes in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      control                  <= CONTROL_RESET;
      nominal_voltage          <= NOMINAL_RESET;
      min_positive_seq_current <= MIN_I_RESET;
      reactive_power_threshold <= Q_THR_RESET;
      angle_limit              <= ANGLE_RESET;
      generator_stage_delay    <= TRIP_DELAY_MS;
      coupling_point_delay     <= TRIP_DELAY_MS;
      irq_enable               <= '0;
    end else if (wr_pending) begin
      if (hit(wr_addr, OFS_CONTROL))     control                  <= hwdata[CTL_WIDTH-1:0];
      if (hit(wr_addr, OFS_NOMINAL))     nominal_voltage          <= hwdata[15:0];
      if (hit(wr_addr, OFS_MIN_CURRENT)) min_positive_seq_current <= hwdata[15:0];
      if (hit(wr_addr, OFS_Q_THRESHOLD)) reactive_power_threshold <= hwdata;
      if (hit(wr_addr, OFS_ANGLE_LIMIT)) angle_limit              <= hwdata[15:0];
      if (hit(wr_addr, OFS_GEN_DELAY))   generator_stage_delay    <= hwdata[15:0];
      if (hit(wr_addr, OFS_PCC_DELAY))   coupling_point_delay     <= hwdata[15:0];
      if (hit(wr_addr, OFS_IRQ_ENABLE))  irq_enable               <= hwdata[EV_WIDTH-1:0];
    end
  end

  // Read data registered at the address phase edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      case (haddr[7:0])
        OFS_CONTROL:     hrdata <= {22'h000000, control};
        OFS_NOMINAL:     hrdata <= {16'h0000, nominal_voltage};
        OFS_MIN_CURRENT: hrdata <= {16'h0000, min_positive_seq_current};
        OFS_Q_THRESHOLD: hrdata <= reactive_power_threshold;
        OFS_ANGLE_LIMIT: hrdata <= {16'h0000, angle_limit};
        OFS_GEN_DELAY:   hrdata <= {16'h0000, generator_stage_delay};
        OFS_PCC_DELAY:   hrdata <= {16'h0000, coupling_point_delay};
        OFS_STATE:       hrdata <= {28'h0000000, blocked, coupling_point_trip,
                                    generator_trip, pickup};
        OFS_IRQ_STATUS:  hrdata <= {29'h00000000, irq_status};
        OFS_IRQ_ENABLE:  hrdata <= {29'h00000000, irq_enable};
        default:         hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // VT fault synchroniser
  // ==========================================================================
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vt_meta <= 1'b0;
      vt_sync <= 1'b0;
    end else begin
      vt_meta <= vt_fault;
      vt_sync <= vt_meta;
    end
  end

  // ==========================================================================
  // Pickup decision
  // ==========================================================================
  always_comb begin
    decoupling_method_select = control[CTL_METHOD] ? METHOD_REACTIVE : METHOD_ANGLE;
    direction_negative       = control[CTL_DIR_NEG];
    function_active = control[CTL_ACTIVE_LSB + 32'(control[CTL_SET_LSB +: 2])];
    blocked = control[CTL_VT_SUP_EN] && vt_sync;
    uv_all = below_ratio(voltage_l1_l2, nominal_voltage) &&
             below_ratio(voltage_l2_l3, nominal_voltage) &&
             below_ratio(voltage_l3_l1, nominal_voltage);
    q_dir = direction_negative ? -33'(positive_seq_reactive_power)
                               :  33'(positive_seq_reactive_power);
    current_ok = positive_seq_current >= min_positive_seq_current;
    case (decoupling_method_select)
      METHOD_ANGLE:    reactive_demand = (q_dir > 33'sh0) && (power_angle >= angle_limit)
                                         && current_ok;
      METHOD_REACTIVE: reactive_demand = (q_dir > 33'(reactive_power_threshold))
                                         && (current_ok || !control[CTL_MIN_I_EN]);
      default:         reactive_demand = 1'b0;
    endcase
    next_pickup = function_active && !blocked && uv_all && reactive_demand;
  end

  // Registered pickup
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pickup   <= 1'b0;
      pickup_q <= 1'b0;
    end else begin
      pickup   <= next_pickup;
      pickup_q <= pickup;
    end
  end

  // ==========================================================================
  // Timers
  // ==========================================================================
  // Tick divider restarts with each pickup
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_div <= 32'h0000_0000;
    end else if (!pickup || tick_div == 32'(TICK_CYCLES_P - 1)) begin
      tick_div <= 32'h0000_0000;
    end else begin
      tick_div <= tick_div + 32'h0000_0001;
    end
  end
  assign tick = pickup && (tick_div == 32'(TICK_CYCLES_P - 1));

  // Both timers start at pickup, clear on dropout
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      generator_stage_timer <= 16'h0000;
      coupling_point_timer  <= 16'h0000;
    end else if (!pickup) begin
      generator_stage_timer <= 16'h0000;
      coupling_point_timer  <= 16'h0000;
    end else if (tick) begin
      if (generator_stage_timer != 16'hffff) generator_stage_timer <= generator_stage_timer + 16'h0001;
      if (coupling_point_timer != 16'hffff)  coupling_point_timer  <= coupling_point_timer + 16'h0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      generator_trip      <= 1'b0;
      coupling_point_trip <= 1'b0;
    end else begin
      generator_trip      <= pickup && next_pickup &&
                             (generator_stage_timer >= generator_stage_delay);
      coupling_point_trip <= pickup && next_pickup &&
                             (coupling_point_timer >= coupling_point_delay);
    end
  end

  // ==========================================================================
  // Interrupts
  // ==========================================================================
  logic gen_trip_q;
  logic pcc_trip_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gen_trip_q <= 1'b0;
      pcc_trip_q <= 1'b0;
    end else begin
      gen_trip_q <= generator_trip;
      pcc_trip_q <= coupling_point_trip;
    end
  end
  assign events = {coupling_point_trip && !pcc_trip_q,
                   generator_trip && !gen_trip_q,
                   pickup && !pickup_q};

  // Sticky status, a new event wins over a clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= '0;
    end else if (wr_pending && hit(wr_addr, OFS_IRQ_CLEAR)) begin
      irq_status <= (irq_status & ~hwdata[EV_WIDTH-1:0]) | events;
    end else begin
      irq_status <= irq_status | events;
    end
  end
  assign irq = |(irq_status & irq_enable);

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Trip needs pickup held through expiry
  AST_TRIP_AFTER_DELAY: assert property (
    $rose(coupling_point_trip) |-> $past(coupling_point_timer) >= coupling_point_delay
                                   && $past(pickup))
    else $error("Coupling trip before delay expired");

  AST_UV_REQUIRED: assert property (
    pickup |-> $past(uv_all && reactive_demand))
    else $error("Pickup without undervoltage and demand");

  AST_DIR_SIGN: assert property (
    direction_negative && positive_seq_reactive_power >= 0 &&
    decoupling_method_select == METHOD_ANGLE |=> !pickup)
    else $error("Negative direction not inverted");

  AST_ANGLE_GATE: assert property (
    decoupling_method_select == METHOD_ANGLE && !current_ok |=> !pickup)
    else $error("Angle method ignored current gate");

  AST_REACTIVE_THR: assert property (
    decoupling_method_select == METHOD_REACTIVE &&
    q_dir <= 33'(reactive_power_threshold) |=> !pickup)
    else $error("Reactive method picked up below threshold");

  AST_TIMERS_TOGETHER: assert property (
    generator_stage_timer == coupling_point_timer)
    else $error("Timers not started together");

  AST_INACTIVE: assert property (
    !function_active |=> !pickup ##1 !coupling_point_trip)
    else $error("Inactive function picked up");

  AST_VT_BLOCK: assert property (
    blocked |=> !pickup)
    else $error("Pickup while VT fault blocks");

  AST_DROPOUT: assert property (
    !pickup |=> coupling_point_timer == 16'h0000 && !generator_trip && !coupling_point_trip)
    else $error("Dropout did not clear timer");

  // Every event lands in the sticky status, even against a clear
  AST_IRQ_LEVEL: assert property (
    |events |=> (irq_status & $past(events)) == $past(events))
    else $error("Event did not set its status bit");

  COV_PCC_TRIP:  cover property ($rose(coupling_point_trip));
  COV_GEN_TRIP:  cover property ($rose(generator_trip));
  COV_DROPOUT:   cover property (pickup ##1 !pickup);
  COV_BLOCKED:   cover property (blocked && uv_all);

endmodule // reactive_undervoltage_decoupling

// ---- testbench/grid_measurement_model.sv ----
// ============================================================================
// Grid side: transformers feeding measurements
// ============================================================================
module grid_measurement_model (
  input  wire logic               hclk,           // Evaluation clock
  input  wire logic [47:0]        set_volts,      // Wanted line-to-line levels
  input  wire logic signed [31:0] set_q,          // Wanted reactive power
  input  wire logic [15:0]        set_i,          // Wanted current
  input  wire logic signed [15:0] set_angle,      // Wanted power angle
  input  wire logic               set_fault,      // Wanted VT fault level
  output logic      [15:0]        voltage_l1_l2,  // Line voltage L1-L2
  output logic      [15:0]        voltage_l2_l3,  // Line voltage L2-L3
  output logic      [15:0]        voltage_l3_l1,  // Line voltage L3-L1
  output logic signed [31:0]      positive_seq_reactive_power,
  output logic      [15:0]        positive_seq_current,
  output logic signed [15:0]      power_angle,
  output logic                    vt_fault
);
  timeunit 1ns;
  timeprecision 1ps;
  // Sampled transformer outputs, one cycle behind the wanted values
  always_ff @(posedge hclk) begin
    voltage_l1_l2               <= set_volts[15:0];
    voltage_l2_l3               <= set_volts[31:16];
    voltage_l3_l1               <= set_volts[47:32];
    positive_seq_reactive_power <= set_q;
    positive_seq_current        <= set_i;
    power_angle                 <= set_angle;
    vt_fault                    <= set_fault;
  end
endmodule // grid_measurement_model

// ---- testbench/reactive_undervoltage_decoupling_test.sv ----
// ============================================================================
// Bench for the decoupling protection
// ============================================================================
module reactive_undervoltage_decoupling_test
  import qv_decoupling_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int T = 10;                  // Cycles per timer tick in sim
  logic hclk, hresetn, hsel, hwrite, hready, hresp, hreadyout, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] v1, v2, v3, cur, r, w;
  logic signed [31:0] qv;
  logic signed [15:0] ang;
  logic fault, generator_trip, coupling_point_trip, pickup, saw, bad;
  logic [47:0] volts;
  logic signed [31:0] q;
  logic [15:0] i_set;
  logic signed [15:0] a_set;
  logic [9:0] ctl;
  int num_errors, checks_done, cycles, tg, tp;
  assign hready = hreadyout;              // Single slave drives the bus ready
  reactive_undervoltage_decoupling #(.TICK_CYCLES_P(T)) i_reactive_undervoltage_decoupling (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .voltage_l1_l2(v1), .voltage_l2_l3(v2),
    .voltage_l3_l1(v3), .positive_seq_reactive_power(qv), .positive_seq_current(cur),
    .power_angle(ang), .vt_fault(fault), .generator_trip(generator_trip),
    .coupling_point_trip(coupling_point_trip), .pickup(pickup), .irq(irq));
  grid_measurement_model i_grid_measurement_model (
    .hclk(hclk), .set_volts(volts), .set_q(q), .set_i(i_set), .set_angle(a_set),
    .set_fault(saw), .voltage_l1_l2(v1), .voltage_l2_l3(v2), .voltage_l3_l1(v3),
    .positive_seq_reactive_power(qv), .positive_seq_current(cur), .power_angle(ang),
    .vt_fault(fault));
  // Clock at 100 MHz
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // Next random value from the shift register
  function logic [15:0] draw();
    r = {r[14:0], r[15] ^ r[13] ^ r[12] ^ r[10]};
    return r;
  endfunction
  // Expected pickup from control word and measurements
  function logic exp_pick(input logic [9:0] c);
    logic signed [32:0] qd;
    logic uv, dem;
    qd = q;
    if (c[7]) qd = -qd;
    uv = 1'b1;
    for (int k = 0; k < 3; k++) uv &= (32'(volts[16*k +: 16]) * 20 < 1000 * 17);
    dem = c[6] ? (qd > 50 && (i_set >= 100 || !c[8])) : (qd > 0 && a_set >= 100 && i_set >= 100);
    return c[c[5:4]] && !(c[9] && saw) && uv && dem;
  endfunction
  // Compare one value
  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One AHB-Lite single word transfer
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1; haddr <= {24'h000000, a}; htrans <= 2'b10; hwrite <= wr; hsize <= 3'b010;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00; hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // Drive a pickup condition or a healthy grid
  task cond(input logic on);
    volts <= on ? {3{16'h0320}} : {3{16'h03e8}};
    q <= 32'h0000_03e8; i_set <= 16'h00c8; a_set <= 16'h00c8; saw <= 1'b0;
    repeat (6) @(posedge hclk);
  endtask
  // Cycles from pickup to each trip
  task measure();
    int n;
    n = 0; tg = 0; tp = 0;
    while (pickup !== 1'b1 && n < 20) begin
      @(posedge hclk); n++;
    end
    for (n = 1; n < 100 && tp == 0; n++) begin
      @(posedge hclk);
      if (tg == 0 && generator_trip === 1'b1) tg = n;
      if (coupling_point_trip === 1'b1) tp = n;
    end
  endtask
  // Verdict and end of run
  task test_done();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Hang guard
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      test_done();
    end
  end
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'b00; hwrite = 1'b0; hsize = 3'b010;
    hwdata = '0; volts = {3{16'h03e8}}; q = '0; i_set = '0; a_set = '0; saw = 1'b0;
    r = 16'd40450; num_errors = 0; checks_done = 0; cycles = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset values and an unmapped word
    xfer(1'b0, OFS_CONTROL, '0); check("control", 32'h0, rd);
    xfer(1'b0, OFS_PCC_DELAY, '0); check("pcc delay", 32'h1f4, rd);
    xfer(1'b0, 8'h2c, '0); check("unmapped", 32'h0, rd);
    check("hresp", 32'h0, {31'h0, hresp});
    xfer(1'b1, OFS_NOMINAL, 32'h3e8); xfer(1'b1, OFS_MIN_CURRENT, 32'h64);
    xfer(1'b1, OFS_Q_THRESHOLD, 32'h32); xfer(1'b1, OFS_ANGLE_LIMIT, 32'h64);
    xfer(1'b1, OFS_GEN_DELAY, 32'h3); xfer(1'b1, OFS_PCC_DELAY, 32'h6);
    xfer(1'b0, OFS_GEN_DELAY, '0); check("gen delay", 32'h3, rd);
    $display("register test done");
    // Random measurements over all methods, directions, gates and sets
    for (int k = 0; k < 64; k++) begin
      w = draw();
      ctl = {w[9:8], k[1:0], w[5:0]};
      xfer(1'b1, OFS_CONTROL, {22'h0, ctl});
      w = draw();
      volts <= {16'h030c + 16'(w[5:0]), 16'h030c + 16'(w[11:6]), 16'h030c + 16'(w[15:9])};
      w = draw();
      q <= {{16{w[15]}}, w};
      w = draw();
      i_set <= {8'h00, w[7:0]};
      w = draw();
      a_set <= {7'h00, w[8:0]};
      saw <= w[9];
      repeat (6) @(posedge hclk);
      check("pickup", {31'h0, exp_pick(ctl)}, {31'h0, pickup});
    end
    $display("random pickup test done");
    // Timer lengths, both started at pickup
    xfer(1'b1, OFS_CONTROL, 32'h001); cond(1'b0);
    xfer(1'b1, OFS_IRQ_CLEAR, 32'h7); xfer(1'b1, OFS_IRQ_ENABLE, 32'h0);
    volts <= {3{16'h0320}};
    measure();
    check("gen time", 32'h1, {31'h0, tg >= 3 * T - 1 && tg <= 3 * T + 3});
    check("pcc time", 32'h1, {31'h0, tp >= 6 * T - 1 && tp <= 6 * T + 3});
    xfer(1'b0, OFS_STATE, '0); check("state", 32'h7, rd);
    xfer(1'b0, OFS_IRQ_STATUS, '0); check("status", 32'h7, rd);
    check("irq masked", 32'h0, {31'h0, irq});
    xfer(1'b1, OFS_IRQ_ENABLE, 32'h2); @(posedge hclk);
    check("irq raised", 32'h1, {31'h0, irq});
    xfer(1'b1, OFS_IRQ_CLEAR, 32'h7); @(posedge hclk);
    check("irq cleared", 32'h0, {31'h0, irq});
    xfer(1'b0, OFS_IRQ_STATUS, '0); check("status clear", 32'h0, rd);
    $display("timer and irq test done");
    // Dropout before expiry, then a fresh full delay
    cond(1'b0);
    volts <= {3{16'h0320}};
    repeat (2 * T) @(posedge hclk);
    volts <= {3{16'h03e8}};
    bad = 1'b0;
    repeat (5 * T) begin
      @(posedge hclk);
      if (generator_trip !== 1'b0 || coupling_point_trip !== 1'b0) bad = 1'b1;
    end
    check("dropout trip", 32'h0, {31'h0, bad});
    volts <= {3{16'h0320}};
    measure();
    check("restart time", 32'h1, {31'h0, tg >= 3 * T - 1 && tg <= 3 * T + 3});
    $display("dropout test done");
    test_done();
  end
endmodule // reactive_undervoltage_decoupling_test
